// ==== logic/fbf_pkg.sv ====
// Functional notes
// - One byte-wide data port register lets the host write bytes into and read bytes out of a 64-byte first-in first-out store.
// - The store is the parallel/serial conversion point for every bit stream that the transmitter sends and the receiver collects.
// - Writing 1 to bit 7 of the level register empties the store at once and clears the overrun error, and the bit reads as 0.
// - A six-bit threshold in bits 5..0 resets to 08h and sets the level for both the near-full and near-empty indications.
// - The near-full flag is 1 exactly when 64 minus the stored count is at most the threshold.
// - The near-empty flag is 1 exactly when the stored count is at most the threshold.
// - Writing 1 to bit 7 of the control register halts the timer at once, and the bit reads as 0.
// - Writing 1 to bit 6 of the control register starts the timer at once, and the bit reads as 0.
// - Bits 2..0 of the control register report the valid bits of the last received byte, 000b meaning all eight.
// - Writing 1 to bit 7 of the bit-framing register starts transmission only while the send-and-receive command is active.
// - Bits 6..4 of the bit-framing register place the first received bit; later bits follow and wrap into bit 0 of the next byte.
// - Bits 2..0 of the bit-framing register set how many bits of the final byte are sent, 000b meaning the whole byte.
package fbf_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [5:0] ADDR_DATA_PORT = 6'h09;
  localparam logic [5:0] ADDR_FILL_LEVEL = 6'h0a;
  localparam logic [5:0] ADDR_WARN_THRESH = 6'h0b;
  localparam logic [5:0] ADDR_MISC_CTRL = 6'h0c;
  localparam logic [5:0] ADDR_BIT_FRAME = 6'h0d;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CLEAR_STROBE_BIT = 7;
  localparam int TIMER_STOP_BIT = 7;
  localparam int TIMER_START_BIT = 6;
  localparam int TX_GO_BIT = 7;
  localparam int RX_ALIGN_LSB = 4;
  localparam int TX_LAST_LSB = 0;

  // ----------------------------------------
  // Reset values and depths
  // ----------------------------------------
  localparam logic [5:0] WARN_THRESH_RESET = 6'h08;
  localparam logic [7:0] MISC_CTRL_FIXED = 8'h10;
  localparam logic [2:0] ALIGN_RESET = 3'h0;
  localparam logic [2:0] TX_LAST_RESET = 3'h0;
  localparam int STORE_DEPTH_DEF = 64;
  localparam int STAGE_DEPTH_DEF = 16;

  // ----------------------------------------
  // Transmit serialiser states
  // ----------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_LOAD,
    TX_SHIFT
  } fbf_tx_state_e;

endpackage

// ==== logic/fbf_fifo.sv ====
`timescale 1ns/10ps
module fbf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  output logic [$clog2(DEPTH):0] level_o
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("fbf_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] lvl_q, lvl_d;
  logic push, pop;

  // Handshake terms
  assign in_ready_o = (lvl_q != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_o = (lvl_q != '0);
  assign out_data_o = mem[rd_q];
  assign level_o = lvl_q;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Pointer and level update, flush wins
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    lvl_d = lvl_q;
    if (flush_i) begin
      wr_d = '0;
      rd_d = '0;
      lvl_d = '0;
    end else begin
      if (push) begin
        wr_d = wr_q + AW'(1);
      end
      if (pop) begin
        rd_d = rd_q + AW'(1);
      end
      lvl_d = lvl_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_q <= '0;
      rd_q <= '0;
      lvl_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      lvl_q <= lvl_d;
    end
  end

  // Storage array, no reset needed
  always_ff @(posedge clk_i) begin
    if (push && !flush_i) begin
      mem[wr_q] <= in_data_i;
    end
  end

endmodule

// ==== logic/fbf_frame_ctrl.sv ====
`timescale 1ns/10ps
module fbf_frame_ctrl #(
  parameter int STORE_DEPTH = fbf_pkg::STORE_DEPTH_DEF,
  parameter int STAGE_DEPTH = fbf_pkg::STAGE_DEPTH_DEF
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic transceive_active_i,
  output logic tx_bit_o,
  output logic tx_bit_valid_o,
  output logic tx_bit_last_o,
  input wire logic tx_bit_ready_i,
  input wire logic rx_bit_i,
  input wire logic rx_bit_valid_i,
  input wire logic rx_frame_end_i,
  output logic rx_bit_ready_o,
  output logic timer_stop_strobe_o,
  output logic timer_start_strobe_o,
  output logic queue_overrun_error_o,
  output logic near_full_flag_o,
  output logic near_empty_flag_o
);

  localparam int LW = $clog2(STORE_DEPTH) + 1;
  localparam int SW = $clog2(STAGE_DEPTH) + 1;

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (STORE_DEPTH > 64 || STAGE_DEPTH < 2) begin : g_param_chk
    $error("fbf_frame_ctrl store depth above 64 or stage depth below 2");
  end

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic wr_data, rd_data, wr_level, wr_thresh, wr_ctrl, wr_frame;
  assign wr_data = reg_wr_i && reg_addr_i == fbf_pkg::ADDR_DATA_PORT;
  assign rd_data = reg_rd_i && reg_addr_i == fbf_pkg::ADDR_DATA_PORT;
  assign wr_level = reg_wr_i && reg_addr_i == fbf_pkg::ADDR_FILL_LEVEL;
  assign wr_thresh = reg_wr_i && reg_addr_i == fbf_pkg::ADDR_WARN_THRESH;
  assign wr_ctrl = reg_wr_i && reg_addr_i == fbf_pkg::ADDR_MISC_CTRL;
  assign wr_frame = reg_wr_i && reg_addr_i == fbf_pkg::ADDR_BIT_FRAME;

  logic clear_now;
  assign clear_now = wr_level && reg_wdata_i[fbf_pkg::CLEAR_STROBE_BIT];

  // ----------------------------------------
  // Byte store and receive staging queue
  // ----------------------------------------
  logic st_in_valid, st_in_ready, st_out_valid, st_out_ready;
  logic [7:0] st_in_data, st_out_data;
  logic [LW-1:0] st_level;
  logic sg_in_valid, sg_in_ready, sg_out_valid, sg_out_ready;
  logic [7:0] sg_in_data, sg_out_data;
  logic [SW-1:0] sg_level;
  logic tx_pop;

  // Host write has priority; received bytes drain when the port is idle
  assign st_in_valid = wr_data | (sg_out_valid & ~wr_data);
  assign st_in_data = wr_data ? reg_wdata_i : sg_out_data;
  assign sg_out_ready = ~wr_data & st_in_ready;
  assign st_out_ready = rd_data | tx_pop;

  fbf_fifo #(.WIDTH(8), .DEPTH(STORE_DEPTH)) u_store (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .flush_i(clear_now),
    .in_valid_i(st_in_valid),
    .in_data_i(st_in_data),
    .in_ready_o(st_in_ready),
    .out_valid_o(st_out_valid),
    .out_data_o(st_out_data),
    .out_ready_i(st_out_ready),
    .level_o(st_level)
  );

  fbf_fifo #(.WIDTH(8), .DEPTH(STAGE_DEPTH)) u_stage (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .flush_i(clear_now),
    .in_valid_i(sg_in_valid),
    .in_data_i(sg_in_data),
    .in_ready_o(sg_in_ready),
    .out_valid_o(sg_out_valid),
    .out_data_o(sg_out_data),
    .out_ready_i(sg_out_ready),
    .level_o(sg_level)
  );

  // ----------------------------------------
  // Control registers and flags
  // ----------------------------------------
  logic [5:0] thresh_q, thresh_d;
  logic [2:0] align_q, align_d, txlast_q, txlast_d;
  logic ovf_q, ovf_d, nfull_q, nfull_d, nempty_q, nempty_d;
  logic stop_q, stop_d, start_q, start_d, go_q, go_d;
  logic [7:0] lvl8, free8;

  assign lvl8 = 8'(st_level);
  assign free8 = 8'(STORE_DEPTH) - lvl8;

  // Next values of control fields, strobes and flags
  always_comb begin
    thresh_d = wr_thresh ? reg_wdata_i[5:0] : thresh_q;
    align_d = wr_frame ? reg_wdata_i[fbf_pkg::RX_ALIGN_LSB +: 3] : align_q;
    txlast_d = wr_frame ? reg_wdata_i[fbf_pkg::TX_LAST_LSB +: 3] : txlast_q;
    stop_d = wr_ctrl && reg_wdata_i[fbf_pkg::TIMER_STOP_BIT];
    start_d = wr_ctrl && reg_wdata_i[fbf_pkg::TIMER_START_BIT];
    go_d = wr_frame && reg_wdata_i[fbf_pkg::TX_GO_BIT] && transceive_active_i;
    ovf_d = ovf_q;
    if (clear_now) begin
      ovf_d = 1'b0;
    end
    if (wr_data && !st_in_ready) begin
      ovf_d = 1'b1;
    end
    nfull_d = free8 <= {2'h0, thresh_q};
    nempty_d = lvl8 <= {2'h0, thresh_q};
  end

  // Registers of the control group
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      thresh_q <= fbf_pkg::WARN_THRESH_RESET;
      align_q <= fbf_pkg::ALIGN_RESET;
      txlast_q <= fbf_pkg::TX_LAST_RESET;
      stop_q <= 1'b0;
      start_q <= 1'b0;
      go_q <= 1'b0;
      ovf_q <= 1'b0;
      nfull_q <= 1'b0;
      nempty_q <= 1'b1;
    end else begin
      thresh_q <= thresh_d;
      align_q <= align_d;
      txlast_q <= txlast_d;
      stop_q <= stop_d;
      start_q <= start_d;
      go_q <= go_d;
      ovf_q <= ovf_d;
      nfull_q <= nfull_d;
      nempty_q <= nempty_d;
    end
  end

  assign timer_stop_strobe_o = stop_q;
  assign timer_start_strobe_o = start_q;
  assign queue_overrun_error_o = ovf_q;
  assign near_full_flag_o = nfull_q;
  assign near_empty_flag_o = nempty_q;

  // ----------------------------------------
  // Transmit serialiser
  // ----------------------------------------
  fbf_pkg::fbf_tx_state_e tx_st_q, tx_st_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] left_q, left_d;
  logic lastbyte_q, lastbyte_d, txv_q, txv_d, txl_q, txl_d;

  // Pop a byte, shift it out LSB first, trim the final byte
  always_comb begin
    tx_st_d = tx_st_q;
    sh_d = sh_q;
    left_d = left_q;
    lastbyte_d = lastbyte_q;
    txv_d = txv_q;
    txl_d = txl_q;
    tx_pop = 1'b0;
    unique case (tx_st_q)
      fbf_pkg::TX_IDLE: begin
        if (go_q) begin
          tx_st_d = fbf_pkg::TX_LOAD;
        end
      end
      fbf_pkg::TX_LOAD: begin
        if (!st_out_valid) begin
          tx_st_d = fbf_pkg::TX_IDLE;
        end else if (!rd_data) begin
          tx_pop = 1'b1;
          sh_d = st_out_data;
          lastbyte_d = st_level == LW'(1);
          left_d = (lastbyte_d && txlast_q != 3'h0) ? {1'b0, txlast_q} : 4'h8;
          txv_d = 1'b1;
          txl_d = lastbyte_d && left_d == 4'h1;
          tx_st_d = fbf_pkg::TX_SHIFT;
        end
      end
      fbf_pkg::TX_SHIFT: begin
        if (tx_bit_ready_i) begin
          sh_d = {1'b0, sh_q[7:1]};
          left_d = left_q - 4'h1;
          txl_d = lastbyte_q && left_d == 4'h1;
          if (left_q == 4'h1) begin
            txv_d = 1'b0;
            txl_d = 1'b0;
            tx_st_d = fbf_pkg::TX_LOAD;
          end
        end
      end
      // Unused state code falls back to idle
      default: begin
        tx_st_d = fbf_pkg::TX_IDLE;
      end
    endcase
  end

  // Registers of the transmit group
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_st_q <= fbf_pkg::TX_IDLE;
      sh_q <= 8'h00;
      left_q <= 4'h0;
      lastbyte_q <= 1'b0;
      txv_q <= 1'b0;
      txl_q <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      sh_q <= sh_d;
      left_q <= left_d;
      lastbyte_q <= lastbyte_d;
      txv_q <= txv_d;
      txl_q <= txl_d;
    end
  end

  assign tx_bit_o = sh_q[0];
  assign tx_bit_valid_o = txv_q;
  assign tx_bit_last_o = txl_q;

  // ----------------------------------------
  // Receive assembler
  // ----------------------------------------
  logic [7:0] acc_q, acc_d, acc_w;
  logic [2:0] pos_q, pos_d, bpos, rxlast_q, rxlast_d;
  logic act_q, act_d, have_q, have_d, rdy_q, rdy_d;

  // Place bits from the chosen start position and push whole bytes
  always_comb begin
    bpos = act_q ? pos_q : align_q;
    acc_w = act_q ? acc_q : 8'h00;
    acc_d = acc_q;
    pos_d = pos_q;
    have_d = have_q;
    act_d = act_q;
    rxlast_d = rxlast_q;
    sg_in_valid = 1'b0;
    if (rx_bit_valid_i) begin
      acc_w[bpos] = rx_bit_i;
      act_d = 1'b1;
      if (bpos == 3'h7) begin
        sg_in_valid = 1'b1;
        acc_d = 8'h00;
        pos_d = 3'h0;
        have_d = 1'b0;
      end else begin
        acc_d = acc_w;
        pos_d = bpos + 3'h1;
        have_d = 1'b1;
      end
    end
    if (rx_frame_end_i) begin
      if (have_d && act_d) begin
        sg_in_valid = 1'b1;
      end
      rxlast_d = have_d ? pos_d : 3'h0;
      act_d = 1'b0;
      have_d = 1'b0;
      acc_d = 8'h00;
      pos_d = 3'h0;
    end
    rdy_d = sg_level < SW'(STAGE_DEPTH - 1);
  end

  assign sg_in_data = acc_w;

  // Registers of the receive group
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      acc_q <= 8'h00;
      pos_q <= 3'h0;
      act_q <= 1'b0;
      have_q <= 1'b0;
      rxlast_q <= 3'h0;
      rdy_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      pos_q <= pos_d;
      act_q <= act_d;
      have_q <= have_d;
      rxlast_q <= rxlast_d;
      rdy_q <= rdy_d;
    end
  end

  assign rx_bit_ready_o = rdy_q;

  // ----------------------------------------
  // Read data path
  // ----------------------------------------
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;

  // Strobe bits read as zero; unmapped offsets read zero
  always_comb begin
    rvalid_d = reg_rd_i;
    rdata_d = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        fbf_pkg::ADDR_DATA_PORT: rdata_d = st_out_valid ? st_out_data : 8'h00;
        fbf_pkg::ADDR_FILL_LEVEL: rdata_d = {1'b0, 7'(st_level)};
        fbf_pkg::ADDR_WARN_THRESH: rdata_d = {2'h0, thresh_q};
        fbf_pkg::ADDR_MISC_CTRL: rdata_d = fbf_pkg::MISC_CTRL_FIXED | {5'h00, rxlast_q};
        fbf_pkg::ADDR_BIT_FRAME: rdata_d = {1'b0, align_q, 1'b0, txlast_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Registers of the read path
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_overrun_set;
    @(posedge clk_i) disable iff (reset_i) (wr_data && !st_in_ready) |=> ovf_q;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun flag not set");

  property p_overrun_keep_level;
    @(posedge clk_i) disable iff (reset_i)
      (wr_data && !st_in_ready && !st_out_ready && !clear_now) |=> st_level == $past(st_level);
  endproperty
  a_overrun_keep_level: assert property (p_overrun_keep_level) else $error("count moved on drop");

  property p_clear_empties;
    @(posedge clk_i) disable iff (reset_i) clear_now |=> (st_level == '0 && !ovf_q) || wr_data;
  endproperty
  a_clear_empties: assert property (p_clear_empties) else $error("clear left data");

  property p_count_up;
    @(posedge clk_i) disable iff (reset_i)
      (wr_data && st_in_ready && !st_out_ready && !clear_now) |=> st_level == $past(st_level) + LW'(1);
  endproperty
  a_count_up: assert property (p_count_up) else $error("count did not rise");

  property p_near_full;
    @(posedge clk_i) disable iff (reset_i) ##1 nfull_q == ($past(free8) <= {2'h0, $past(thresh_q)});
  endproperty
  a_near_full: assert property (p_near_full) else $error("near-full flag wrong");

  property p_near_empty;
    @(posedge clk_i) disable iff (reset_i) ##1 nempty_q == ($past(lvl8) <= {2'h0, $past(thresh_q)});
  endproperty
  a_near_empty: assert property (p_near_empty) else $error("near-empty flag wrong");

  property p_stop_pulse;
    @(posedge clk_i) disable iff (reset_i)
      (wr_ctrl && reg_wdata_i[fbf_pkg::TIMER_STOP_BIT]) |=> stop_q ##1 (!stop_q || $past(wr_ctrl));
  endproperty
  a_stop_pulse: assert property (p_stop_pulse) else $error("stop strobe wrong");

  property p_start_pulse;
    @(posedge clk_i) disable iff (reset_i) start_q |-> $past(wr_ctrl && reg_wdata_i[fbf_pkg::TIMER_START_BIT]);
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start strobe without write");

  property p_go_gated;
    @(posedge clk_i) disable iff (reset_i) (wr_frame && !transceive_active_i) |=> !go_q;
  endproperty
  a_go_gated: assert property (p_go_gated) else $error("send started outside transceive");

  property p_go_starts;
    @(posedge clk_i) disable iff (reset_i)
      (go_q && tx_st_q == fbf_pkg::TX_IDLE && st_out_valid) |-> ##[1:3] tx_bit_valid_o;
  endproperty
  a_go_starts: assert property (p_go_starts) else $error("send did not begin");

  property p_ctrl_read;
    @(posedge clk_i) disable iff (reset_i)
      (reg_rd_i && reg_addr_i == fbf_pkg::ADDR_MISC_CTRL) |=> reg_rdata_o[7:6] == 2'h0 && reg_rdata_o[2:0] == rxlast_q;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

  property p_align_first;
    @(posedge clk_i) disable iff (reset_i)
      (!act_q && rx_bit_valid_i && !rx_frame_end_i && align_q != 3'h7) |=> pos_q == $past(align_q) + 3'h1;
  endproperty
  a_align_first: assert property (p_align_first) else $error("first bit misplaced");

  property p_tx_trim;
    @(posedge clk_i) disable iff (reset_i)
      (tx_pop && st_level == LW'(1) && txlast_q != 3'h0) |=> left_q == {1'b0, $past(txlast_q)};
  endproperty
  a_tx_trim: assert property (p_tx_trim) else $error("final byte length wrong");

endmodule

// ==== verification/fbf_link_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Bit-level link partner
// ----------------------------------------
module fbf_link_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic tx_bit_i,
  input wire logic tx_bit_valid_i,
  input wire logic tx_bit_last_i,
  output logic tx_bit_ready_o,
  output logic rx_bit_o,
  output logic rx_bit_valid_o,
  output logic rx_frame_end_o,
  input wire logic rx_bit_ready_i
);
  logic [15:0] got_q;
  int got_n;
  int last_at;

  // Receive lines idle at time zero
  initial begin
    rx_bit_o = 1'b0;
    rx_bit_valid_o = 1'b0;
    rx_frame_end_o = 1'b0;
  end

  // Bit sink, ready only on every other cycle so the sender must stall
  always @(posedge clk_i) begin
    if (reset_i) begin
      tx_bit_ready_o <= 1'b0;
      got_n <= 0;
      last_at <= -1;
    end else begin
      tx_bit_ready_o <= ~tx_bit_ready_o;
      if (tx_bit_valid_i && tx_bit_ready_o) begin
        got_q[got_n] <= tx_bit_i;
        got_n <= got_n + 1;
        if (tx_bit_last_i) begin
          last_at <= got_n;
        end
      end
    end
  end

  // Sends n bits first to last, frame end with the final one
  task automatic send_rx(input logic [15:0] bits, input int n, output bit ok);
    int k;
    ok = 1'b0;
    for (k = 0; k < 100 && !ok; k++) begin
      @(posedge clk_i);
      ok = (rx_bit_ready_i === 1'b1);
    end
    if (ok) begin
      for (k = 0; k < n; k++) begin
        rx_bit_o <= bits[k];
        rx_bit_valid_o <= 1'b1;
        rx_frame_end_o <= (k == n - 1);
        @(posedge clk_i);
      end
      rx_bit_valid_o <= 1'b0;
      rx_frame_end_o <= 1'b0;
      rx_bit_o <= ~bits[n-1];
    end
  endtask
endmodule

// ==== verification/fbf_frame_ctrl_bench.sv ====
`timescale 1ns/10ps
module fbf_frame_ctrl_bench;
  localparam logic [5:0] A_DATA = fbf_pkg::ADDR_DATA_PORT;
  localparam logic [5:0] A_LVL = fbf_pkg::ADDR_FILL_LEVEL;
  localparam logic [5:0] A_THR = fbf_pkg::ADDR_WARN_THRESH;
  localparam logic [5:0] A_CTL = fbf_pkg::ADDR_MISC_CTRL;
  localparam logic [5:0] A_BF = fbf_pkg::ADDR_BIT_FRAME;
  logic clk_i;
  logic reset_i;
  logic [5:0] reg_addr_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] reg_rdata_o;
  logic reg_rvalid_o;
  logic transceive_active_i;
  logic tx_bit_o;
  logic tx_bit_valid_o;
  logic tx_bit_last_o;
  logic tx_bit_ready_i;
  logic rx_bit_i;
  logic rx_bit_valid_i;
  logic rx_frame_end_i;
  logic rx_bit_ready_o;
  logic timer_stop_strobe_o;
  logic timer_start_strobe_o;
  logic queue_overrun_error_o;
  logic near_full_flag_o;
  logic near_empty_flag_o;
  int bad_count;
  int checked;

  fbf_frame_ctrl i_dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .transceive_active_i(transceive_active_i), .tx_bit_o(tx_bit_o), .tx_bit_valid_o(tx_bit_valid_o),
    .tx_bit_last_o(tx_bit_last_o), .tx_bit_ready_i(tx_bit_ready_i), .rx_bit_i(rx_bit_i),
    .rx_bit_valid_i(rx_bit_valid_i), .rx_frame_end_i(rx_frame_end_i), .rx_bit_ready_o(rx_bit_ready_o),
    .timer_stop_strobe_o(timer_stop_strobe_o), .timer_start_strobe_o(timer_start_strobe_o),
    .queue_overrun_error_o(queue_overrun_error_o), .near_full_flag_o(near_full_flag_o),
    .near_empty_flag_o(near_empty_flag_o));

  fbf_link_model i_link (.clk_i(clk_i), .reset_i(reset_i), .tx_bit_i(tx_bit_o), .tx_bit_valid_i(tx_bit_valid_o),
    .tx_bit_last_i(tx_bit_last_o), .tx_bit_ready_o(tx_bit_ready_i), .rx_bit_o(rx_bit_i),
    .rx_bit_valid_o(rx_bit_valid_i), .rx_frame_end_o(rx_frame_end_i), .rx_bit_ready_i(rx_bit_ready_o));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_sim();
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("read answer", 16'h0001, reg_rvalid_o);
    d = reg_rdata_o;
  endtask

  task automatic rchk(input string what, input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic run_reset_values();
    rchk("level", A_LVL, 8'h00);
    rchk("threshold", A_THR, 8'h08);
    rchk("control", A_CTL, 8'h10);
    rchk("framing", A_BF, 8'h00);
    wr(6'h0e, 8'hff);
    rchk("unmapped", 6'h0e, 8'h00);
    chk("near empty", 16'h0001, near_empty_flag_o);
  endtask

  task automatic run_fill_levels();
    int n;
    wr(A_THR, 8'hc4);
    rchk("threshold", A_THR, 8'h04);
    for (n = 1; n <= 64; n++) begin
      wr(A_DATA, n[7:0]);
      repeat (2) @(posedge clk_i);
      #1;
      chk("near full", 16'((64 - n) <= 4), near_full_flag_o);
      chk("near empty", 16'(n <= 4), near_empty_flag_o);
    end
    rchk("level full", A_LVL, 8'h40);
    wr(A_DATA, 8'hee);
    rchk("level after overrun", A_LVL, 8'h40);
    chk("overrun", 16'h0001, queue_overrun_error_o);
    rchk("first byte", A_DATA, 8'h01);
    rchk("second byte", A_DATA, 8'h02);
    rchk("level after reads", A_LVL, 8'h3e);
    wr(A_LVL, 8'h80);
    rchk("level after clear", A_LVL, 8'h00);
    chk("overrun cleared", 16'h0000, queue_overrun_error_o);
  endtask

  task automatic run_timer_strobes();
    wr(A_CTL, 8'h80);
    #1;
    chk("stop strobe", 16'h0002, {timer_stop_strobe_o, timer_start_strobe_o});
    @(posedge clk_i);
    #1;
    chk("stop strobe end", 16'h0000, {timer_stop_strobe_o, timer_start_strobe_o});
    wr(A_CTL, 8'h40);
    #1;
    chk("start strobe", 16'h0001, {timer_stop_strobe_o, timer_start_strobe_o});
    rchk("control strobes", A_CTL, 8'h10);
  endtask

  task automatic run_transmit();
    int k;
    wr(A_DATA, 8'ha5);
    wr(A_DATA, 8'h3c);
    wr(A_BF, 8'h83);
    repeat (20) @(posedge clk_i);
    #1;
    chk("send without command", 16'h0000, tx_bit_valid_o);
    rchk("level kept", A_LVL, 8'h02);
    rchk("framing", A_BF, 8'h03);
    @(posedge clk_i);
    transceive_active_i <= 1'b1;
    wr(A_BF, 8'h83);
    for (k = 0; k < 300 && i_link.got_n < 11; k++) begin
      @(posedge clk_i);
    end
    if (k == 300) begin
      bad_count++;
      end_sim();
    end
    chk("sent bits", 16'h04a5, i_link.got_q[10:0]);
    chk("final bit marker", 16'h000a, i_link.last_at[15:0]);
    @(posedge clk_i);
    transceive_active_i <= 1'b0;
  endtask

  task automatic run_receive();
    bit ok;
    logic [7:0] d;
    wr(A_BF, 8'h70);
    rchk("alignment", A_BF, 8'h70);
    i_link.send_rx(16'h002d, 6, ok);
    chk("receiver ready", 16'h0001, ok);
    repeat (6) @(posedge clk_i);
    rchk("received level", A_LVL, 8'h02);
    rd(A_DATA, d);
    chk("first received byte", 16'h0080, d & 8'h80);
    rd(A_DATA, d);
    chk("second received byte", 16'h0016, d & 8'h1f);
    rchk("last byte bits", A_CTL, 8'h15);
    wr(A_BF, 8'h00);
  endtask

  // Clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Main sequence
  initial begin
    bad_count = 0;
    checked = 0;
    reset_i = 1'b1;
    reg_addr_i = 6'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_wdata_i = 8'h00;
    transceive_active_i = 1'b0;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    run_reset_values();
    run_fill_levels();
    run_timer_strobes();
    run_transmit();
    run_receive();
    end_sim();
  end
endmodule
